// *** verilog/mci_pkg.sv ***
// Constants, address fields and decode functions of the memory channel interleaver
package mci_pkg;

  localparam int ADDR_W = 32;
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_W = 8;
  localparam int CHAN_LSB = 8;
  localparam int VPIPE_W = 3;
  localparam int QUAD_LSB = 9;
  localparam int ROW_LSB = 11;
  localparam int ROW_PHASE_W = 4;
  localparam int CHAN_ID_W = 4;
  localparam int CHAN_PER_QUAD = 3;
  localparam int NUM_CH_MAX = 12;
  localparam int L2_BYTES = 65536;
  localparam int L2_LINE_BYTES = 64;
  localparam int L2_LINE_LSB = $clog2(L2_LINE_BYTES);
  localparam int L2_LINE_W = $clog2(L2_BYTES / L2_LINE_BYTES);
  localparam int WAVE_ITEMS = 64;
  localparam int LANE_CNT_W = $clog2(WAVE_ITEMS + 1);
  localparam int WG_IDX_W = 32;

  typedef logic [ADDR_W-1:0] mci_addr_t;
  typedef logic [CHAN_ID_W-1:0] mci_chan_t;
  typedef enum logic {MCI_WG_IDLE, MCI_WG_RUN} mci_wg_state_e;

  // Width of the channel field for a channel count
  function automatic int mci_chan_bits(input int nch);
    return (nch == 4) ? 2 : 3;
  endfunction

  // Channel selected by a byte address
  function automatic mci_chan_t mci_chan_sel(input mci_addr_t a, input int nch);
    logic [ROW_PHASE_W-1:0] row;
    logic [1:0] phase;
    mci_chan_t base;
    row = a[ROW_LSB +: ROW_PHASE_W];
    phase = 2'(row % 4'h3);
    // Widened before the product: quadrant 3 times 3 needs four bits
    base = CHAN_ID_W'({2'b00, a[QUAD_LSB +: 2]} * 4'h3);
    if (nch == 12)
    begin
      // Odd phase rows fold both pipes of a quadrant onto its middle channel
      if (phase == 2'h1)
        return base + 4'h1;
      else
        return a[CHAN_LSB] ? base + 4'h2 : base;
    end
    else if (nch == 8)
      return {1'b0, a[CHAN_LSB +: 3]};
    else
      return {2'b0, a[CHAN_LSB +: 2]};
  endfunction

  // Address within a channel: channel field squeezed out
  function automatic mci_addr_t mci_chan_local(input mci_addr_t a, input int nch);
    mci_addr_t hi;
    hi = a >> (CHAN_LSB + mci_chan_bits(nch));
    return (hi << CHAN_LSB) | {24'h0, a[OFFSET_LSB +: OFFSET_W]};
  endfunction

endpackage

// *** verilog/mci_rr_arb.sv ***
// Round-robin arbiter granting one requester per cycle
`timescale 1ns/10ps
`default_nettype none
module mci_rr_arb #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requests and grant
  input wire logic [N-1:0] req,
  output logic [N-1:0] grant
);
  localparam int W = (N > 1) ? $clog2(N) : 1;

  logic [W-1:0] ptr;
  logic [W-1:0] win;
  logic found;

  // Search starts at the requester after the last winner
  always_comb
  begin
    grant = '0;
    win = '0;
    found = 1'b0;
    for (int k = 0; k < N; k++)
    begin
      int j;
      j = (int'(ptr) + k) % N;
      if (!found && req[j])
      begin
        grant[j] = 1'b1;
        win = W'(j);
        found = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr <= '0;
    else if (found)
      ptr <= (int'(win) == N - 1) ? '0 : W'(win + 1'b1);
  end

endmodule
`default_nettype wire

// *** verilog/mci_interleaver.sv ***
// Memory channel interleaver: address steering crossbar and work-group launcher
`timescale 1ns/10ps
`default_nettype none
module mci_interleaver
  import mci_pkg::*;
#(
  parameter int NUM_CH = 12,
  parameter int NUM_CU = 32,
  parameter int BANK_W = 4,
  parameter int WAVE_ID_W = 4,
  parameter int GRP_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Compute unit requests, one wavefront each
  input wire logic [NUM_CU-1:0] cu_valid,
  output logic [NUM_CU-1:0] cu_ready,
  input wire logic [NUM_CU-1:0][mci_pkg::ADDR_W-1:0] cu_addr,
  input wire logic [NUM_CU-1:0][WAVE_ID_W-1:0] cu_wave_id,
  input wire logic [NUM_CU-1:0][mci_pkg::LANE_CNT_W-1:0] cu_lanes,
  // Channel side
  output logic [NUM_CH-1:0] ch_valid,
  input wire logic [NUM_CH-1:0] ch_ready,
  output logic [NUM_CH-1:0][mci_pkg::ADDR_W-1:0] ch_local_addr,
  output logic [NUM_CH-1:0][mci_pkg::OFFSET_W-1:0] ch_offset,
  output logic [NUM_CH-1:0][BANK_W-1:0] ch_bank,
  output logic [NUM_CH-1:0][mci_pkg::L2_LINE_W-1:0] ch_l2_line,
  output logic [NUM_CH-1:0][$clog2(NUM_CU)-1:0] ch_src_cu,
  output logic [NUM_CH-1:0][WAVE_ID_W-1:0] ch_wave_id,
  output logic [NUM_CH-1:0][mci_pkg::LANE_CNT_W-1:0] ch_lanes,
  // Work-group launch control
  input wire logic wg_start,
  input wire logic [GRP_W-1:0] wg_num_x,
  input wire logic [GRP_W-1:0] wg_num_y,
  output logic wg_busy,
  output logic wg_launch_valid,
  output logic [$clog2(NUM_CU)-1:0] wg_launch_cu,
  output logic [mci_pkg::WG_IDX_W-1:0] work_group_launch_index,
  output logic [GRP_W-1:0] work_group_coordinate_x,
  output logic [GRP_W-1:0] work_group_coordinate_y,
  input wire logic [NUM_CU-1:0] cu_wg_done,
  output logic wg_retire_valid,
  output logic [mci_pkg::WG_IDX_W-1:0] wg_retire_index
);
  import mci_pkg::*;

  localparam int CU_W = $clog2(NUM_CU);
  localparam int CNT_W = $clog2(NUM_CU + 1);

  if (!(NUM_CH == 4 || NUM_CH == 8 || NUM_CH == 12))
  begin : g_bad_ch
    $error("NUM_CH must be 4, 8 or 12");
  end
  if (NUM_CU < 2 || GRP_W < 1 || GRP_W > 16 || BANK_W < 1 || LANE_CNT_W < 7)
  begin : g_bad_cfg
    $error("Unsupported NUM_CU, GRP_W, BANK_W or lane width");
  end

  mci_chan_t cu_chan [NUM_CU];
  logic [NUM_CU-1:0] gnt [NUM_CH];

  // Channel decode per compute unit
  always_comb
  begin
    for (int i = 0; i < NUM_CU; i++)
      cu_chan[i] = mci_chan_sel(cu_addr[i], NUM_CH);
  end

  // A unit is accepted only when its channel granted it
  always_comb
  begin
    cu_ready = '0;
    for (int c = 0; c < NUM_CH; c++)
      cu_ready = cu_ready | gnt[c];
  end

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    logic [NUM_CU-1:0] req;
    logic slot_free;
    logic [CU_W-1:0] win;
    logic vld;
    mci_addr_t laddr;
    logic [OFFSET_W-1:0] offs;
    logic [BANK_W-1:0] bank;
    logic [CU_W-1:0] src;
    logic [WAVE_ID_W-1:0] wave;
    logic [LANE_CNT_W-1:0] lanes;

    // Output stage may refill in the cycle the channel drains it
    assign slot_free = !vld || ch_ready[g];

    always_comb
    begin
      req = '0;
      for (int i = 0; i < NUM_CU; i++)
        req[i] = slot_free && cu_valid[i] && (cu_chan[i] == CHAN_ID_W'(g));
    end

    // Kept apart from the request so no process loops through the arbiter
    always_comb
    begin
      win = '0;
      for (int i = 0; i < NUM_CU; i++)
        if (gnt[g][i])
          win = CU_W'(i);
    end

    mci_rr_arb #(.N(NUM_CU)) u_arb (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .req(req),
      .grant(gnt[g])
    );

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        vld <= 1'b0;
      else if (slot_free)
        vld <= |gnt[g];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        laddr <= '0;
        offs <= '0;
        bank <= '0;
        src <= '0;
        wave <= '0;
        lanes <= '0;
      end
      else if (slot_free && |gnt[g])
      begin
        laddr <= mci_chan_local(cu_addr[win], NUM_CH);
        offs <= cu_addr[win][OFFSET_LSB +: OFFSET_W];
        bank <= cu_addr[win][CHAN_LSB + mci_chan_bits(NUM_CH) +: BANK_W];
        src <= win;
        wave <= cu_wave_id[win];
        lanes <= cu_lanes[win];
      end
    end

    assign ch_valid[g] = vld;
    assign ch_local_addr[g] = laddr;
    assign ch_offset[g] = offs;
    assign ch_bank[g] = bank;
    assign ch_l2_line[g] = laddr[L2_LINE_LSB +: L2_LINE_W];
    assign ch_src_cu[g] = src;
    assign ch_wave_id[g] = wave;
    assign ch_lanes[g] = lanes;
  end

  // Work-group launcher
  mci_wg_state_e state;
  logic [NUM_CU-1:0] busy;
  logic [NUM_CU-1:0] done;
  logic [CU_W-1:0] order_q [NUM_CU];
  logic [CU_W-1:0] head;
  logic [CU_W-1:0] tail;
  logic [CNT_W-1:0] count;
  logic [GRP_W-1:0] gx;
  logic [GRP_W-1:0] gy;
  logic [GRP_W-1:0] nx;
  logic [GRP_W-1:0] ny;
  logic [WG_IDX_W-1:0] next_idx;
  logic all_launched;
  logic any_free;
  logic [CU_W-1:0] free_cu;
  logic do_launch;
  logic do_retire;
  logic [NUM_CU-1:0] launch_bit;
  logic [NUM_CU-1:0] retire_bit;

  function automatic logic [CU_W-1:0] ring_inc(input logic [CU_W-1:0] p);
    return (int'(p) == NUM_CU - 1) ? '0 : CU_W'(p + 1'b1);
  endfunction

  always_comb
  begin
    any_free = 1'b0;
    free_cu = '0;
    for (int i = NUM_CU - 1; i >= 0; i--)
    begin
      if (!busy[i])
      begin
        any_free = 1'b1;
        free_cu = CU_W'(i);
      end
    end
  end

  // A unit frees only when retired, so the active window stays contiguous
  assign do_retire = (count != '0) && done[order_q[head]];
  assign do_launch = (state == MCI_WG_RUN) && !all_launched && any_free;
  assign launch_bit = do_launch ? (NUM_CU'(1) << free_cu) : '0;
  assign retire_bit = do_retire ? (NUM_CU'(1) << order_q[head]) : '0;
  assign wg_busy = (state == MCI_WG_RUN);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= MCI_WG_IDLE;
    else
      case (state)
        MCI_WG_IDLE:
          if (wg_start && wg_num_x != '0 && wg_num_y != '0)
            state <= MCI_WG_RUN;
        MCI_WG_RUN:
          if (all_launched && do_retire && count == CNT_W'(1))
            state <= MCI_WG_IDLE;
        default:
          state <= MCI_WG_IDLE;
      endcase
  end

  // Row-major walk, x fastest
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gx <= '0;
      gy <= '0;
      nx <= '0;
      ny <= '0;
      next_idx <= '0;
      all_launched <= 1'b0;
    end
    else if (state == MCI_WG_IDLE && wg_start)
    begin
      gx <= '0;
      gy <= '0;
      nx <= wg_num_x;
      ny <= wg_num_y;
      next_idx <= '0;
      all_launched <= 1'b0;
    end
    else if (do_launch)
    begin
      next_idx <= next_idx + 1'b1;
      if (gx == nx - 1'b1)
      begin
        gx <= '0;
        gy <= gy + 1'b1;
        all_launched <= (gy == ny - 1'b1);
      end
      else
        gx <= gx + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= '0;
      done <= '0;
      head <= '0;
      tail <= '0;
      count <= '0;
    end
    else
    begin
      busy <= (busy | launch_bit) & ~retire_bit;
      // A completion from the retiring unit in its retire cycle is dropped
      done <= (done & ~retire_bit) | (cu_wg_done & busy & ~retire_bit);
      if (do_launch)
        tail <= ring_inc(tail);
      if (do_retire)
        head <= ring_inc(head);
      count <= count + CNT_W'(do_launch) - CNT_W'(do_retire);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CU; i++)
        order_q[i] <= '0;
    end
    else if (do_launch)
      order_q[tail] <= free_cu;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wg_launch_valid <= 1'b0;
      wg_launch_cu <= '0;
      work_group_launch_index <= '0;
      work_group_coordinate_x <= '0;
      work_group_coordinate_y <= '0;
      wg_retire_valid <= 1'b0;
      wg_retire_index <= '0;
    end
    else
    begin
      wg_launch_valid <= do_launch;
      wg_retire_valid <= do_retire;
      if (do_launch)
      begin
        wg_launch_cu <= free_cu;
        work_group_launch_index <= next_idx;
        work_group_coordinate_x <= gx;
        work_group_coordinate_y <= gy;
      end
      // Step after each shown retirement, so gaps between retirements are harmless
      if (wg_retire_valid)
        wg_retire_index <= wg_retire_index + 1'b1;
      // Placed last so a start wins over the final retirement pulse
      if (state == MCI_WG_IDLE && wg_start)
        wg_retire_index <= '0;
    end
  end

endmodule
`default_nettype wire

// *** sim/mci_cu_model.sv ***
// Compute unit model: presents one wavefront request per unit, held until taken
`timescale 1ns/10ps
`default_nettype none
module mci_cu_model
  import mci_pkg::*;
#(
  parameter int NUM_CU = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requests ordered by the bench
  input wire logic [NUM_CU-1:0] go,
  input wire logic [mci_pkg::ADDR_W-1:0] go_addr,
  // Request side of the crossbar
  output logic [NUM_CU-1:0] cu_valid,
  input wire logic [NUM_CU-1:0] cu_ready,
  output logic [NUM_CU-1:0][mci_pkg::ADDR_W-1:0] cu_addr,
  output logic [NUM_CU-1:0][3:0] cu_wave_id,
  output logic [NUM_CU-1:0][mci_pkg::LANE_CNT_W-1:0] cu_lanes
);
  import mci_pkg::*;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cu_valid <= '0;
      cu_addr <= '0;
    end
    else
      for (int i = 0; i < NUM_CU; i++)
        if (cu_valid[i] && cu_ready[i])
        begin
          cu_valid[i] <= 1'b0;
          // Released address shows junk, not the last value
          cu_addr[i] <= ~cu_addr[i];
        end
        else if (go[i] && !cu_valid[i])
        begin
          cu_valid[i] <= 1'b1;
          cu_addr[i] <= go_addr;
        end
  always_comb
    for (int i = 0; i < NUM_CU; i++)
    begin
      cu_wave_id[i] = 4'(i);
      cu_lanes[i] = LANE_CNT_W'(WAVE_ITEMS);
    end
endmodule
`default_nettype wire

// *** sim/mci_interleaver_props.sv ***
// Assertion checker for the memory channel interleaver ports
`timescale 1ns/10ps
`default_nettype none
module mci_interleaver_props
  import mci_pkg::*;
#(
  parameter int NUM_CU = 32,
  parameter int NUM_CH = 12,
  parameter int GRP_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Crossbar
  input wire logic [NUM_CU-1:0] cu_valid,
  input wire logic [NUM_CU-1:0] cu_ready,
  input wire logic [NUM_CH-1:0] ch_valid,
  input wire logic [NUM_CH-1:0] ch_ready,
  input wire logic [NUM_CH-1:0][mci_pkg::ADDR_W-1:0] ch_local_addr,
  input wire logic [NUM_CH-1:0][mci_pkg::OFFSET_W-1:0] ch_offset,
  input wire logic [NUM_CH-1:0][mci_pkg::L2_LINE_W-1:0] ch_l2_line,
  // Launcher
  input wire logic wg_start,
  input wire logic [GRP_W-1:0] wg_num_x,
  input wire logic [GRP_W-1:0] wg_num_y,
  input wire logic wg_busy,
  input wire logic wg_launch_valid,
  input wire logic [mci_pkg::WG_IDX_W-1:0] work_group_launch_index,
  input wire logic [GRP_W-1:0] work_group_coordinate_x,
  input wire logic [GRP_W-1:0] work_group_coordinate_y,
  input wire logic wg_retire_valid,
  input wire logic [mci_pkg::WG_IDX_W-1:0] wg_retire_index
);
  import mci_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic [WG_IDX_W-1:0] exp_li;
  logic [WG_IDX_W-1:0] exp_ri;
  logic [GRP_W-1:0] nx;
  wire logic acc = wg_start && !wg_busy && wg_num_x != '0 && wg_num_y != '0;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      exp_li <= '0;
      exp_ri <= '0;
      nx <= '0;
    end
    else if (acc)
    begin
      exp_li <= '0;
      exp_ri <= '0;
      nx <= wg_num_x;
    end
    else
    begin
      exp_li <= exp_li + 32'(wg_launch_valid);
      exp_ri <= exp_ri + 32'(wg_retire_valid);
    end
  sequence s_start;
    acc;
  endsequence
  property p_start;
    s_start |=> wg_busy ##1 wg_launch_valid;
  endproperty
  a_start: assert property (p_start) else $error("late first launch");
  property p_index;
    wg_launch_valid |-> work_group_launch_index == exp_li;
  endproperty
  a_index: assert property (p_index) else $error("launch index out of order");
  property p_coord;
    wg_launch_valid |-> work_group_launch_index ==
      32'(work_group_coordinate_x) + 32'(work_group_coordinate_y) * 32'(nx);
  endproperty
  a_coord: assert property (p_coord) else $error("coordinates off index");
  property p_retire;
    wg_retire_valid |-> wg_retire_index == exp_ri && exp_ri < exp_li;
  endproperty
  a_retire: assert property (p_retire) else $error("retire out of order");
  property p_idle;
    !wg_busy |-> !wg_launch_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("launch while idle");
  property p_grants;
    $countones(cu_ready) <= NUM_CH;
  endproperty
  a_grants: assert property (p_grants) else $error("too many grants");
  property p_accept;
    |(cu_valid & cu_ready) |=> |ch_valid;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted request lost");
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    property p_hold;
      ch_valid[c] && !ch_ready[c] |=> ch_valid[c] && $stable(ch_local_addr[c]);
    endproperty
    a_hold: assert property (p_hold) else $error("channel request dropped");
    property p_fields;
      ch_valid[c] |-> ch_offset[c] == ch_local_addr[c][7:0] &&
        ch_l2_line[c] == ch_local_addr[c][15:6];
    endproperty
    a_fields: assert property (p_fields) else $error("field mismatch");
  end
endmodule
bind mci_interleaver mci_interleaver_props #(.NUM_CU(NUM_CU), .NUM_CH(NUM_CH), .GRP_W(GRP_W))
  u_props (.ref_clk(ref_clk), .rst_n(rst_n), .cu_valid(cu_valid), .cu_ready(cu_ready),
  .ch_valid(ch_valid), .ch_ready(ch_ready), .ch_local_addr(ch_local_addr),
  .ch_offset(ch_offset), .ch_l2_line(ch_l2_line), .wg_start(wg_start),
  .wg_num_x(wg_num_x), .wg_num_y(wg_num_y), .wg_busy(wg_busy),
  .wg_launch_valid(wg_launch_valid), .work_group_launch_index(work_group_launch_index),
  .work_group_coordinate_x(work_group_coordinate_x),
  .work_group_coordinate_y(work_group_coordinate_y), .wg_retire_valid(wg_retire_valid),
  .wg_retire_index(wg_retire_index));
`default_nettype wire

// *** sim/memory_channel_interleaver_bench.sv ***
// Testbench: address map, channel conflicts, work-group launch and retire order
`timescale 1ns/10ps
`default_nettype none
module memory_channel_interleaver_bench;
  import mci_pkg::*;
  localparam logic [3:0] PAT_A [8] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hb};
  localparam logic [3:0] PAT_B [8] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h7, 4'h7, 4'ha, 4'ha};
  localparam logic [31:0] CORNER [7] = '{32'h0, 32'h100, 32'h800, 32'h7800, 32'h8000,
    32'h8800, 32'hffffffff};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] go = '0;
  logic [31:0] go_addr = '0;
  logic [3:0] cu_valid;
  logic [3:0] cu_ready;
  logic [3:0][31:0] cu_addr;
  logic [3:0][3:0] cu_wave_id;
  logic [3:0][LANE_CNT_W-1:0] cu_lanes;
  logic [11:0] ch_valid;
  logic [11:0] ch_ready = '1;
  logic [11:0][31:0] ch_local_addr;
  logic [11:0][7:0] ch_offset;
  logic [11:0][3:0] ch_bank;
  logic [11:0][L2_LINE_W-1:0] ch_l2_line;
  logic [11:0][1:0] ch_src_cu;
  logic [11:0][3:0] ch_wave_id;
  logic [11:0][LANE_CNT_W-1:0] ch_lanes;
  logic wg_start = 1'b0;
  logic [15:0] wg_num_x = '0;
  logic [15:0] wg_num_y = '0;
  logic wg_busy;
  logic wg_launch_valid;
  logic [1:0] wg_launch_cu;
  logic [31:0] work_group_launch_index;
  logic [15:0] work_group_coordinate_x;
  logic [15:0] work_group_coordinate_y;
  logic [3:0] cu_wg_done = '0;
  logic wg_retire_valid;
  logic [31:0] wg_retire_index;
  int fail_count = 0;
  int n_compared = 0;
  int n_launch = 0;
  int n_retire = 0;
  int ex_nx = 1;
  always #4 ref_clk = ~ref_clk;
  mci_cu_model #(.NUM_CU(4)) cus (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
    .go_addr(go_addr), .cu_valid(cu_valid), .cu_ready(cu_ready), .cu_addr(cu_addr),
    .cu_wave_id(cu_wave_id), .cu_lanes(cu_lanes));
  mci_interleaver #(.NUM_CU(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cu_valid(cu_valid), .cu_ready(cu_ready), .cu_addr(cu_addr), .cu_wave_id(cu_wave_id),
    .cu_lanes(cu_lanes), .ch_valid(ch_valid), .ch_ready(ch_ready),
    .ch_local_addr(ch_local_addr), .ch_offset(ch_offset), .ch_bank(ch_bank),
    .ch_l2_line(ch_l2_line), .ch_src_cu(ch_src_cu), .ch_wave_id(ch_wave_id),
    .ch_lanes(ch_lanes),
    .wg_start(wg_start), .wg_num_x(wg_num_x), .wg_num_y(wg_num_y), .wg_busy(wg_busy),
    .wg_launch_valid(wg_launch_valid), .wg_launch_cu(wg_launch_cu),
    .work_group_launch_index(work_group_launch_index),
    .work_group_coordinate_x(work_group_coordinate_x),
    .work_group_coordinate_y(work_group_coordinate_y), .cu_wg_done(cu_wg_done),
    .wg_retire_valid(wg_retire_valid), .wg_retire_index(wg_retire_index));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  function automatic logic [3:0] exp_ch(input logic [31:0] a);
    if (a[14:11] % 3 == 1)
      return PAT_B[a[10:8]];
    return PAT_A[a[10:8]];
  endfunction
  task automatic req_one(input logic [31:0] a);
    logic [31:0] loc;
    logic [3:0] c;
    int n;
    c = exp_ch(a);
    loc = ((a >> 11) << 8) | 32'(a[7:0]);
    ch_ready = 12'($urandom);
    go_addr = a;
    go = 4'h1;
    @(negedge ref_clk);
    go = '0;
    for (n = 0; n < 8 && ch_valid === '0; n++)
      @(negedge ref_clk);
    chk("channel", 32'h1 << c, 32'(ch_valid));
    chk("local addr", loc, ch_local_addr[c]);
    chk("offset", 32'(a[7:0]), 32'(ch_offset[c]));
    chk("bank", 32'(a[14:11]), 32'(ch_bank[c]));
    chk("l2 line", 32'(loc[15:6]), 32'(ch_l2_line[c]));
    chk("lanes", 32'(WAVE_ITEMS), 32'(ch_lanes[c]));
    chk("src cu", 0, 32'(ch_src_cu[c]));
    chk("wave id", 0, 32'(ch_wave_id[c]));
    ch_ready = '1;
    @(negedge ref_clk);
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge ref_clk)
  begin
    if (wg_launch_valid === 1'b1)
    begin
      chk("launch index", n_launch, work_group_launch_index);
      chk("coord x", n_launch % ex_nx, 32'(work_group_coordinate_x));
      chk("coord y", n_launch / ex_nx, 32'(work_group_coordinate_y));
      if (n_launch < 4)
        chk("launch cu", n_launch, 32'(wg_launch_cu));
      n_launch++;
    end
    if (wg_retire_valid === 1'b1)
    begin
      chk("retire index", n_retire, wg_retire_index);
      n_retire++;
    end
  end
  initial
  begin
    #100000;
    fail_count++;
    close_out;
  end
  initial
  begin
    logic [1:0] s0;
    s0 = 2'($urandom(6));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    foreach (CORNER[i])
      req_one(CORNER[i]);
    repeat (40) req_one($urandom);
    // Two units hit the same bank of channel 2 while it stalls
    ch_ready[2] = 1'b0;
    go_addr = 32'h100;
    go = 4'h3;
    @(negedge ref_clk);
    go = '0;
    chk("grants", 1, 32'($countones(cu_ready)));
    @(negedge ref_clk);
    s0 = ch_src_cu[2];
    chk("refused", 0, 32'(cu_ready));
    repeat (3) @(negedge ref_clk);
    chk("held src", 32'(s0), 32'(ch_src_cu[2]));
    ch_ready[2] = 1'b1;
    @(negedge ref_clk);
    chk("second src", 32'(s0 ^ 2'h1), 32'(ch_src_cu[2]));
    chk("second wave", 32'(s0 ^ 2'h1), 32'(ch_wave_id[2]));
    @(negedge ref_clk);
    // Six groups on four units, a start while busy is ignored
    ex_nx = 3;
    wg_num_x = 16'h3;
    wg_num_y = 16'h2;
    wg_start = 1'b1;
    @(negedge ref_clk);
    wg_start = 1'b0;
    wg_num_x = 16'h7;
    repeat (3) @(negedge ref_clk);
    wg_start = 1'b1;
    @(negedge ref_clk);
    wg_start = 1'b0;
    for (int n = 0; n < 300 && wg_busy === 1'b1; n++)
    begin
      cu_wg_done = 4'($urandom);
      @(negedge ref_clk);
    end
    cu_wg_done = '0;
    @(negedge ref_clk);
    chk("launched", 6, n_launch);
    chk("retired", 6, n_retire);
    wg_num_x = '0;
    wg_start = 1'b1;
    @(negedge ref_clk);
    wg_start = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("busy", 0, 32'(wg_busy));
    close_out;
  end
endmodule
`default_nettype wire
